// >>> ssw_supervisor.sv
// Purpose: Supply supervisor with reset hold, watchdog and power-fail output.
// Assumes: Comparator results arrive as digital levels; floating kick is flagged by the pad.
// Notes: Hold and watchdog periods are parameters so simulation can shorten them.
`timescale 1ns/1ps
`default_nettype none
module ssw_supervisor #(
	parameter logic [31:0] HOLD_CYCLES = ssw_pkg::HOLD_CNT,
	parameter logic [31:0] WDOG_CYCLES = ssw_pkg::WDOG_CNT,
	parameter bit HAS_WATCHDOG = 1'b1
) (
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// Comparator and pin inputs, all asynchronous.
	input wire logic supply_low_i,
	input wire logic manual_reset_n_i,
	input wire logic watchdog_kick_i,
	input wire logic watchdog_kick_float_i,
	input wire logic power_fail_sense_low_i,
	// Outputs.
	output logic sys_reset_n_o,
	output logic sys_reset_o,
	output logic watchdog_timeout_n_o,
	output logic power_fail_n_o
);
	logic supply_low_s;
	logic manual_n_s;
	logic kick_s;
	logic float_s;
	logic pf_low_s;
	logic kick_prev_reg;
	logic kick_edge;
	logic reset_cause;
	logic wdog_en;
	logic expired_reg;
	logic [31:0] hold_cnt_reg;
	logic [31:0] wdog_cnt_reg;
	logic [31:0] quiet_cnt_reg;
	ssw_pkg::ssw_state_e state_reg;

	// Terminal test shared by the hold and watchdog counters.
	// Both counters stop one short of their limit, so a limit of one still works.
	function automatic logic ssw_at_limit(input logic [31:0] cnt, input logic [31:0] limit);
		return cnt >= limit - 32'h1;
	endfunction

	// Supply low defaults to asserted so reset holds through the first cycles.
	ssw_sync #(
		.RST_VAL(1'b1)
	) u_sync_supply (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.d_i(supply_low_i),
		.q_o(supply_low_s)
	);

	// Manual reset defaults to pressed, so a release is always followed by a full hold.
	ssw_sync #(
		.RST_VAL(1'b0)
	) u_sync_manual (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.d_i(manual_reset_n_i),
		.q_o(manual_n_s)
	);

	// Kick defaults to the idle level that the processor shows while held in reset.
	ssw_sync #(
		.RST_VAL(1'b0)
	) u_sync_kick (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.d_i(watchdog_kick_i),
		.q_o(kick_s)
	);

	// Floating defaults to set, so the watchdog stays off until the pad says otherwise.
	ssw_sync #(
		.RST_VAL(1'b1)
	) u_sync_float (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.d_i(watchdog_kick_float_i),
		.q_o(float_s)
	);

	// Power-fail sense defaults to low, so the output reports a failure until proven good.
	ssw_sync #(
		.RST_VAL(1'b1)
	) u_sync_pf (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.d_i(power_fail_sense_low_i),
		.q_o(pf_low_s)
	);

	assign reset_cause = supply_low_s | ~manual_n_s;
	assign wdog_en = HAS_WATCHDOG && !float_s;

	// Counts cycles since the last reset cause; it only feeds the hold-length checks below.
	// It saturates rather than wraps, so a long quiet run cannot look like a fresh release.
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			quiet_cnt_reg <= 32'h0;
		end else if (reset_cause) begin
			quiet_cnt_reg <= 32'h0;
		end else if (quiet_cnt_reg != 32'hffffffff) begin
			quiet_cnt_reg <= quiet_cnt_reg + 32'h1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg <= ssw_pkg::SSW_HOLD;
			hold_cnt_reg <= 32'h0;
		end else begin
			case (state_reg)
				ssw_pkg::SSW_HOLD: begin
					hold_cnt_reg <= 32'h0;
					if (!reset_cause) begin
						state_reg <= ssw_pkg::SSW_TIME;
					end
				end
				ssw_pkg::SSW_TIME: begin
					// A new cause restarts the full hold, which also debounces the switch.
					if (reset_cause) begin
						state_reg <= ssw_pkg::SSW_HOLD;
					end else if (ssw_at_limit(hold_cnt_reg, HOLD_CYCLES)) begin
						state_reg <= ssw_pkg::SSW_RUN;
					end else begin
						hold_cnt_reg <= hold_cnt_reg + 32'h1;
					end
				end
				ssw_pkg::SSW_RUN: begin
					if (reset_cause) begin
						state_reg <= ssw_pkg::SSW_HOLD;
					end
				end
				default: begin
					state_reg <= ssw_pkg::SSW_HOLD;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sys_reset_n_o <= ssw_pkg::RESET_N_RST;
		end else begin
			sys_reset_n_o <= (state_reg == ssw_pkg::SSW_RUN) && !reset_cause;
		end
	end
	assign sys_reset_o = ~sys_reset_n_o;

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			kick_prev_reg <= 1'b0;
		end else begin
			kick_prev_reg <= kick_s;
		end
	end
	assign kick_edge = kick_s ^ kick_prev_reg;

	// Expiry does not touch the reset path; the system wires timeout to manual reset if wanted.
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wdog_cnt_reg <= 32'h0;
			expired_reg <= 1'b0;
		end else if (!sys_reset_n_o || !wdog_en || kick_edge) begin
			wdog_cnt_reg <= 32'h0;
			expired_reg <= 1'b0;
		end else if (ssw_at_limit(wdog_cnt_reg, WDOG_CYCLES)) begin
			expired_reg <= 1'b1;
		end else begin
			wdog_cnt_reg <= wdog_cnt_reg + 32'h1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			watchdog_timeout_n_o <= ssw_pkg::WDOG_N_RST;
		end else begin
			watchdog_timeout_n_o <= !supply_low_s && !expired_reg;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			power_fail_n_o <= ssw_pkg::PFAIL_N_RST;
		end else begin
			power_fail_n_o <= !pf_low_s;
		end
	end

	a_reset_low_supply: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		supply_low_s |=> !sys_reset_n_o) else $error("reset released during low supply");
	a_reset_hold_time: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		$rose(state_reg == ssw_pkg::SSW_TIME) |-> !sys_reset_n_o [*2])
		else $error("reset released before hold");
	a_reset_complement: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		sys_reset_o == !sys_reset_n_o) else $error("active-high reset not complement");
	a_manual_reset: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		!manual_n_s |=> !sys_reset_n_o ##1 !sys_reset_n_o) else $error("manual reset ignored");
	a_wdog_expire: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(wdog_cnt_reg == WDOG_CYCLES - 32'h1 && sys_reset_n_o && wdog_en && !kick_edge)
		|=> expired_reg ##1 !watchdog_timeout_n_o) else $error("watchdog did not expire");
	a_wdog_sticky: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(expired_reg && sys_reset_n_o && wdog_en && !kick_edge) |=> expired_reg)
		else $error("expiry cleared without counter clear");
	a_kick_clear: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		kick_edge |=> wdog_cnt_reg == 32'h0) else $error("kick edge did not clear counter");
	a_reset_clear: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		!sys_reset_n_o |=> wdog_cnt_reg == 32'h0 && !expired_reg) else $error("counter ran in reset");
	a_low_forces_timeout: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		supply_low_s |=> !watchdog_timeout_n_o) else $error("timeout not forced low");
	a_timeout_release: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(!supply_low_s && !expired_reg) |=> watchdog_timeout_n_o) else $error("timeout not released");
	a_float_disable: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		float_s |=> !expired_reg) else $error("watchdog ran while floating");
	a_power_fail: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		power_fail_n_o == !$past(pf_low_s)) else $error("power-fail output wrong");

	// The release lands exactly two cycles after the hold count is used up: one to enter
	// the run state and one for the registered output. These two checks pin both ends.
	a_hold_minimum: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		sys_reset_n_o |-> quiet_cnt_reg >= HOLD_CYCLES + 32'h2)
		else $error("reset released before full hold");
	a_hold_release: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		quiet_cnt_reg == HOLD_CYCLES + 32'h2 |-> sys_reset_n_o)
		else $error("reset not released after hold");
	a_hold_range: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		hold_cnt_reg <= HOLD_CYCLES - 32'h1) else $error("hold counter overran");
	a_state_legal: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		state_reg inside {ssw_pkg::SSW_HOLD, ssw_pkg::SSW_TIME, ssw_pkg::SSW_RUN})
		else $error("illegal sequencer state");
	a_expire_not_early: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		$rose(expired_reg) |-> wdog_cnt_reg >= WDOG_CYCLES - 32'h1)
		else $error("watchdog expired early");
	a_kick_restart: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		kick_edge |=> !expired_reg) else $error("kick edge left expiry set");
	// Without a watchdog the timeout output only ever reports low supply.
	a_variant_no_wdog: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		!HAS_WATCHDOG |-> !expired_reg) else $error("watchdog ran in variant without it");

	c_reset_release: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) $rose(sys_reset_n_o));
	c_wdog_timeout: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) $fell(watchdog_timeout_n_o));
	c_manual_press: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) sys_reset_n_o ##1 !manual_n_s);
	c_power_fail: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) $fell(power_fail_n_o));
	c_kick_restart: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		kick_edge && sys_reset_n_o && wdog_cnt_reg != 32'h0);
endmodule
`default_nettype wire

// >>> ssw_pkg.sv
// Purpose: Shared constants for the supply supervisor and watchdog.
// Assumes: A 200 MHz block clock.
// Notes: Cycle counts derive from the printed times.
`default_nettype none
package ssw_pkg;
	localparam longint unsigned CLK_HZ = 64'd200000000;
	localparam longint unsigned HOLD_TIME_MS = 64'd200;
	localparam longint unsigned WDOG_TIME_MS = 64'd1600;
	localparam longint unsigned HOLD_CYCLES = (CLK_HZ / 64'd1000) * HOLD_TIME_MS;
	localparam longint unsigned WDOG_CYCLES = (CLK_HZ / 64'd1000) * WDOG_TIME_MS;
	localparam int CNT_W = 32;
	localparam logic [31:0] HOLD_CNT = HOLD_CYCLES[31:0];
	localparam logic [31:0] WDOG_CNT = WDOG_CYCLES[31:0];
	localparam logic RESET_N_RST = 1'b0;
	localparam logic WDOG_N_RST = 1'b0;
	localparam logic PFAIL_N_RST = 1'b0;
	typedef enum logic [1:0] {
		SSW_HOLD = 2'b00,
		SSW_TIME = 2'b01,
		SSW_RUN = 2'b11
	} ssw_state_e;
endpackage
`default_nettype wire

// >>> ssw_sync.sv
// Purpose: Two-flop synchroniser for an asynchronous level.
// Assumes: One clock; reset value given as parameter.
// Notes: The first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module ssw_sync #(
	parameter logic RST_VAL = 1'b0
) (
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// Level.
	input wire logic d_i,
	output logic q_o
);
	logic meta_reg;
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_reg <= RST_VAL;
			q_o <= RST_VAL;
		end else begin
			meta_reg <= d_i;
			q_o <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// >>> ssw_cpu_model.sv
// Purpose: Processor model that receives reset and toggles the kick line.
// Assumes: The same clock as the supervisor.
// Notes: The kick line stays quiet while the processor is held in reset.
`timescale 1ns/1ps
`default_nettype none
module ssw_cpu_model (
	// Clock and reset seen by the processor.
	input wire logic clk_sys_i,
	input wire logic sys_reset_n_i,
	// Kick control from the bench.
	input wire logic kick_en_i,
	// Kick line.
	output logic watchdog_kick_o
);
	logic [2:0] tick_reg;
	// A kick every 8 cycles stays well inside the watchdog window.
	// The timeout output is taken as an interrupt only, never looped to manual reset.
	always_ff @(posedge clk_sys_i) begin
		if (!sys_reset_n_i) begin
			tick_reg <= 3'h0;
			watchdog_kick_o <= 1'b0;
		end else if (kick_en_i) begin
			tick_reg <= tick_reg + 3'h1;
			if (tick_reg == 3'h7) begin
				watchdog_kick_o <= ~watchdog_kick_o;
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb_supply_supervisor_watchdog.sv
// Purpose: Self-checking bench for the supply supervisor and watchdog.
// Assumes: Shortened hold and watchdog counts.
// Notes: Kicks come from the processor model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_supply_supervisor_watchdog;
	localparam int HOLD = 20;
	localparam int WDOG = 50;
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic supply_low_i = 1'b1;
	logic manual_reset_n_i = 1'b1;
	logic watchdog_kick_i;
	logic watchdog_kick_float_i = 1'b0;
	logic power_fail_sense_low_i = 1'b0;
	logic kick_en = 1'b0;
	logic sys_reset_n_o, sys_reset_o, watchdog_timeout_n_o, power_fail_n_o;
	logic plain_reset_n, plain_reset, plain_timeout_n, plain_pfail_n;
	int err_count = 0;
	int comparisons = 0;
	ssw_supervisor #(.HOLD_CYCLES(32'(HOLD)), .WDOG_CYCLES(32'(WDOG)), .HAS_WATCHDOG(1'b1)) uut (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .supply_low_i(supply_low_i),
		.manual_reset_n_i(manual_reset_n_i), .watchdog_kick_i(watchdog_kick_i),
		.watchdog_kick_float_i(watchdog_kick_float_i), .power_fail_sense_low_i(power_fail_sense_low_i),
		.sys_reset_n_o(sys_reset_n_o), .sys_reset_o(sys_reset_o),
		.watchdog_timeout_n_o(watchdog_timeout_n_o), .power_fail_n_o(power_fail_n_o));
	// Variant without a watchdog, fed the same inputs.
	ssw_supervisor #(.HOLD_CYCLES(32'(HOLD)), .WDOG_CYCLES(32'(WDOG)), .HAS_WATCHDOG(1'b0)) uut_plain (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .supply_low_i(supply_low_i),
		.manual_reset_n_i(manual_reset_n_i), .watchdog_kick_i(watchdog_kick_i),
		.watchdog_kick_float_i(watchdog_kick_float_i), .power_fail_sense_low_i(power_fail_sense_low_i),
		.sys_reset_n_o(plain_reset_n), .sys_reset_o(plain_reset),
		.watchdog_timeout_n_o(plain_timeout_n), .power_fail_n_o(plain_pfail_n));
	ssw_cpu_model cpu (.clk_sys_i(clk_sys_i), .sys_reset_n_i(sys_reset_n_o), .kick_en_i(kick_en),
		.watchdog_kick_o(watchdog_kick_i));
	initial begin
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	// Sampling 1 ns after the edge lets the edge's register updates land first.
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic wait_out(input bit sel, input logic val, input int n);
		int i;
		i = 0;
		while ((sel ? watchdog_timeout_n_o : sys_reset_n_o) !== val && i < n) begin
			cyc(1);
			i++;
		end
	endtask
	task automatic finish_test;
		$display("comparisons=%0d err_count=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic power_up;
		cyc(10);
		`CHK(sys_reset_n_o, 1'b0)
		`CHK(sys_reset_o, 1'b1)
		`CHK(plain_reset, 1'b1)
		`CHK(watchdog_timeout_n_o, 1'b0)
		supply_low_i <= 1'b0;
		cyc(6);
		`CHK(watchdog_timeout_n_o, 1'b1)
		cyc(HOLD - 8);
		`CHK(sys_reset_n_o, 1'b0)
		wait_out(1'b0, 1'b1, 16);
		`CHK(sys_reset_n_o, 1'b1)
		`CHK(sys_reset_o, 1'b0)
	endtask
	task automatic wdog_expiry;
		cyc(WDOG - 12);
		`CHK(watchdog_timeout_n_o, 1'b1)
		wait_out(1'b1, 1'b0, 24);
		`CHK(watchdog_timeout_n_o, 1'b0)
		cyc(20);
		`CHK(watchdog_timeout_n_o, 1'b0)
		`CHK(sys_reset_n_o, 1'b1)
		`CHK(plain_timeout_n, 1'b1)
		`CHK(plain_reset, 1'b0)
		`CHK(plain_pfail_n, 1'b1)
		kick_en <= 1'b1;
		wait_out(1'b1, 1'b1, 20);
		`CHK(watchdog_timeout_n_o, 1'b1)
		cyc(3 * WDOG);
		`CHK(watchdog_timeout_n_o, 1'b1)
	endtask
	task automatic manual_pulse;
		manual_reset_n_i <= 1'b0;
		cyc(6);
		`CHK(sys_reset_n_o, 1'b0)
		manual_reset_n_i <= 1'b1;
		cyc(HOLD - 4);
		`CHK(sys_reset_n_o, 1'b0)
		wait_out(1'b0, 1'b1, 16);
		`CHK(sys_reset_n_o, 1'b1)
	endtask
	task automatic float_kick;
		kick_en <= 1'b0;
		watchdog_kick_float_i <= 1'b1;
		cyc(3 * WDOG);
		`CHK(watchdog_timeout_n_o, 1'b1)
		supply_low_i <= 1'b1;
		cyc(6);
		`CHK(watchdog_timeout_n_o, 1'b0)
		`CHK(sys_reset_n_o, 1'b0)
		supply_low_i <= 1'b0;
		cyc(6);
		`CHK(watchdog_timeout_n_o, 1'b1)
	endtask
	task automatic power_fail;
		power_fail_sense_low_i <= 1'b1;
		cyc(6);
		`CHK(power_fail_n_o, 1'b0)
		power_fail_sense_low_i <= 1'b0;
		cyc(6);
		`CHK(power_fail_n_o, 1'b1)
	endtask
	initial begin
		cyc(6);
		reset_n_i <= 1'b1;
		power_up();
		wdog_expiry();
		manual_pulse();
		power_fail();
		float_kick();
		finish_test();
	end
	initial begin
		#20000;
		err_count++;
		finish_test();
	end
endmodule
`default_nettype wire
